// ===== hdl/low_timer.sv
// Purpose: millisecond count of how long a synchronised active-low line stays low
// Assumes: tick is a one-cycle enable every millisecond
// Notes:   the count saturates and clears as soon as the line is high
`timescale 1ns/1ps
module low_timer #(
  parameter int unsigned W = 14
) (
  input  wire logic         clk,      // system clock
  input  wire logic         reset,    // synchronous reset
  input  wire logic         tick,     // millisecond enable
  input  wire logic         line_n,   // synchronised line, low active
  output logic [W-1:0]      ms        // low time in ms
);
  always_ff @(posedge clk) begin
    if (reset || line_n) begin
      ms <= '0;
    end else if (tick && ms != {W{1'b1}}) begin
      ms <= ms + 1'b1;
    end
  end
endmodule : low_timer

// ===== hdl/module_power_mode_sequencer.sv
// Purpose: operating mode and restart sequencer of a cellular modem module
// Assumes: 20 MHz clock, pins asynchronous, supervisors report faults as levels
// Notes:   ignition and emergency reset low times measured on a 1 ms tick
`timescale 1ns/1ps
module module_power_mode_sequencer
  import power_seq_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
) (
  input  wire logic                       clk,                // system clock
  input  wire logic                       reset,              // synchronous reset
  input  wire logic                       power_on_trigger_n, // ignition pin
  input  wire logic                       emergency_reset_n,  // emergency reset pin
  input  wire logic                       main_supply,        // supply present
  input  wire logic                       fault,              // voltage/temp fault
  input  wire power_seq_pkg::activity_t   activity,           // link activity
  input  wire logic                       restart_cmd,        // restart command pulse
  input  wire logic                       init_done,          // firmware init done
  output power_seq_pkg::mode_t            mode,               // current mode
  output logic                            core_reset,         // processor held reset
  output logic                            rtc_only,           // only rtc regulator on
  output logic                            radio_on,           // radio enabled
  output logic                            radio_cmd_reject,   // refuse radio commands
  output logic                            volatile_clear,     // wipe volatile state
  output power_seq_pkg::port_lines_t      port_lines          // primary port lines
);
  import power_seq_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and millisecond tick
  // ----------------------------------------------------------------
  logic [2:0]             ign_sync;
  logic [2:0]             rst_sync;
  logic                   ign_n;
  logic                   erst_n;
  logic [$clog2(TICK_CYC)-1:0] tick_cnt;
  logic                   tick;
  logic [MS_W-1:0]        ign_ms;
  logic [MS_W-1:0]        rst_ms;
  logic [MS_W-1:0]        boot_ms;
  logic                   rst_fired;
  mode_t                  next_mode;

  always_ff @(posedge clk) begin
    if (reset) begin
      ign_sync <= 3'h7;
      rst_sync <= 3'h7;
    end else begin
      ign_sync <= {ign_sync[1:0], power_on_trigger_n};
      rst_sync <= {rst_sync[1:0], emergency_reset_n};
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      ign_n  <= 1'b1;
      erst_n <= 1'b1;
    end else begin
      if (ign_sync[1] == ign_sync[2]) begin
        ign_n <= ign_sync[2];
      end
      if (rst_sync[1] == rst_sync[2]) begin
        erst_n <= rst_sync[2];
      end
    end
  end

  // free-running, never stopped by mode changes
  always_ff @(posedge clk) begin
    if (reset) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == $bits(tick_cnt)'(TICK_CYC - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // low duration timers
  // ----------------------------------------------------------------
  low_timer #(.W(MS_W)) ign_timer (
    .clk    (clk),
    .reset  (reset),
    .tick   (tick),
    .line_n (ign_n),
    .ms     (ign_ms)
  );

  low_timer #(.W(MS_W)) rst_timer (
    .clk    (clk),
    .reset  (reset),
    .tick   (tick),
    .line_n (erst_n),
    .ms     (rst_ms)
  );

  // a held reset restarts again once boot has begun; the flag only spaces restarts
  always_ff @(posedge clk) begin
    if (reset || erst_n) begin
      rst_fired <= 1'b0;
    end else if (mode == MODE_RESET) begin
      rst_fired <= 1'b1;
    end else if (mode == MODE_BOOT) begin
      rst_fired <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || mode != MODE_BOOT) begin
      boot_ms <= '0;
    end else if (tick && boot_ms != {MS_W{1'b1}}) begin
      boot_ms <= boot_ms + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // mode sequencing
  // ----------------------------------------------------------------
  function automatic mode_t run_mode(input activity_t a);
    if (a.airplane_req) begin
      run_mode = MODE_AIRPLANE;
    end else if (a.call_active || a.data_active) begin
      run_mode = MODE_ACTIVE;
    end else if (a.power_save_en && (a.usb_suspended || !a.usb_present)
                 && !a.port_active) begin
      run_mode = MODE_SLEEP;
    end else begin
      run_mode = MODE_IDLE;
    end
  endfunction : run_mode

  logic running;
  assign running = (mode != MODE_DOWN) && (mode != MODE_RESET);

  always_comb begin
    next_mode = mode;
    if (!main_supply) begin
      next_mode = MODE_DOWN;
    end else if (running && rst_ms > MS_W'(RST_OFF_MS)) begin
      next_mode = MODE_DOWN;
    end else if (running && !rst_fired && rst_ms > MS_W'(RST_MIN_MS)) begin
      next_mode = MODE_RESET;
    end else if (running && fault) begin
      next_mode = MODE_DOWN;
    end else begin
      unique case (mode)
        MODE_DOWN: begin
          // level triggered: a line tied low restarts with no edge
          if (!ign_n && ign_ms > MS_W'(IGN_MIN_MS) && erst_n) begin
            next_mode = MODE_BOOT;
          end
        end
        MODE_RESET: begin
          next_mode = MODE_BOOT;
        end
        MODE_BOOT: begin
          if (boot_ms >= MS_W'(BOOT_MS) && init_done) begin
            next_mode = run_mode(activity);
          end
        end
        MODE_IDLE, MODE_SLEEP, MODE_ACTIVE, MODE_AIRPLANE: begin
          if (restart_cmd) begin
            next_mode = MODE_RESET;
          end else begin
            next_mode = run_mode(activity);
          end
        end
        default: next_mode = MODE_DOWN;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode <= MODE_DOWN;
    end else begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      core_reset       <= 1'b1;
      rtc_only         <= 1'b1;
      radio_on         <= 1'b0;
      radio_cmd_reject <= 1'b1;
      volatile_clear   <= 1'b1;
      port_lines       <= 3'h7;
    end else begin
      core_reset       <= (next_mode == MODE_DOWN) || (next_mode == MODE_RESET);
      rtc_only         <= (next_mode == MODE_DOWN);
      radio_on         <= (next_mode == MODE_IDLE) || (next_mode == MODE_SLEEP)
                          || (next_mode == MODE_ACTIVE);
      radio_cmd_reject <= (next_mode == MODE_AIRPLANE) || (next_mode == MODE_DOWN);
      volatile_clear   <= (next_mode == MODE_RESET) || (next_mode == MODE_DOWN);
      // lines stay high through reset and boot; low marks firmware ready
      port_lines       <= (next_mode == MODE_DOWN || next_mode == MODE_RESET
                           || next_mode == MODE_BOOT) ? 3'h7 : 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence held_reset_s;
    running && !rst_fired && rst_ms > MS_W'(RST_MIN_MS) && rst_ms <= MS_W'(RST_OFF_MS)
      && main_supply;
  endsequence

  reset_restart_a: assert property (@(posedge clk) disable iff (reset)
    held_reset_s |=> mode == MODE_RESET ##1 mode == MODE_BOOT)
    else $error("held emergency reset did not restart");

  long_reset_off_a: assert property (@(posedge clk) disable iff (reset)
    (running && main_supply && rst_ms > MS_W'(RST_OFF_MS)) |=> mode == MODE_DOWN)
    else $error("long emergency reset did not switch off");

  ignition_start_a: assert property (@(posedge clk) disable iff (reset)
    (mode == MODE_DOWN && main_supply && !ign_n && erst_n && ign_ms > MS_W'(IGN_MIN_MS))
      |=> mode == MODE_BOOT)
    else $error("ignition level did not start module");

  fault_off_a: assert property (@(posedge clk) disable iff (reset)
    (running && main_supply && fault && rst_ms <= MS_W'(RST_MIN_MS)) |=> mode == MODE_DOWN)
    else $error("fault did not switch off");

  down_rtc_a: assert property (@(posedge clk) disable iff (reset)
    mode == MODE_DOWN |-> rtc_only && core_reset && !radio_on)
    else $error("power down left logic powered");

  airplane_radio_a: assert property (@(posedge clk) disable iff (reset)
    mode == MODE_AIRPLANE |-> !radio_on && radio_cmd_reject)
    else $error("airplane mode kept radio");

  wipe_on_reset_a: assert property (@(posedge clk) disable iff (reset)
    mode == MODE_RESET |-> volatile_clear)
    else $error("emergency reset kept volatile state");

  ready_lines_a: assert property (@(posedge clk) disable iff (reset)
    (mode == MODE_BOOT ##1 mode == MODE_IDLE) |-> port_lines == 3'h0)
    else $error("port lines not low after init");

  restart_cmd_a: assert property (@(posedge clk) disable iff (reset)
    (mode == MODE_IDLE && restart_cmd && main_supply && !fault && erst_n)
      |=> mode == MODE_RESET)
    else $error("restart command ignored");

  tick_period_a: assert property (@(posedge clk) disable iff (reset)
    tick |=> !tick)
    else $error("tick longer than one cycle");

endmodule : module_power_mode_sequencer

// ===== shared/power_seq_pkg.sv
// Purpose: constants and types shared by the power mode sequencer
// Assumes: 20 MHz system clock
// Notes:   times are kept in their printed unit, cycle counts derive from them
package power_seq_pkg;

  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned TICK_US           = 1000;
  localparam int unsigned TICK_CYCLES       = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned IGN_MIN_MS        = 300;
  localparam int unsigned RST_MIN_MS        = 200;
  localparam int unsigned RST_OFF_MS        = 8000;
  localparam int unsigned BOOT_MS           = 50;
  localparam int unsigned MS_W              = 14;

  typedef enum logic [2:0] {
    MODE_DOWN    = 3'b000,
    MODE_BOOT    = 3'b001,
    MODE_IDLE    = 3'b010,
    MODE_SLEEP   = 3'b011,
    MODE_ACTIVE  = 3'b100,
    MODE_AIRPLANE = 3'b101,
    MODE_RESET   = 3'b110
  } mode_t;

  typedef struct packed {
    logic call_active;
    logic data_active;
    logic usb_suspended;
    logic usb_present;
    logic port_active;
    logic power_save_en;
    logic airplane_req;
  } activity_t;

  typedef struct packed {
    logic clear_to_send;
    logic data_set_ready;
    logic ring_indicator;
  } port_lines_t;

endpackage : power_seq_pkg

// ===== test/host_controller.sv
// Purpose: host controller model that drives ignition and emergency reset
// Assumes: both lines are open drain with pull-ups, so a released line reads high
// Notes:   hold times are given in ms, one ms being TICK_CYC clock cycles
`timescale 1ns/1ps
module host_controller #(
  parameter int unsigned TICK_CYC = 4
) (
  input  wire logic clk,    // system clock
  output logic      ign_n,  // ignition line
  output logic      rst_n   // emergency reset line
);
  initial begin
    ign_n = 1'b1;
    rst_n = 1'b1;
  end

  // a start is only relied on when the caller passes more than 300 ms
  task automatic hold_ign(input int ms);
    @(negedge clk);
    ign_n = 1'b0;
    repeat (ms * TICK_CYC) @(negedge clk);
    ign_n = 1'b1;
  endtask : hold_ign

  task automatic set_ign(input logic lvl);
    @(negedge clk);
    ign_n = lvl;
  endtask : set_ign

  // only issued once the module is treated as unresponsive
  task automatic hold_rst(input int ms);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (ms * TICK_CYC) @(negedge clk);
    rst_n = 1'b1;
  endtask : hold_rst
endmodule : host_controller

// ===== test/tb_module_power_mode_sequencer.sv
// Purpose: self-checking bench of the power mode sequencer
// Assumes: shortened ms tick of 4 cycles so the 8000 ms hold fits the run
// Notes:   inputs change on the falling edge, outputs are read there too
`timescale 1ns/1ps
module tb_module_power_mode_sequencer;
  import power_seq_pkg::*;
  localparam int unsigned TICK = 4;
  localparam logic [6:0] ACTS [8] = '{7'h10, 7'h12, 7'h02, 7'h0A,
                                      7'h16, 7'h52, 7'h32, 7'h41};
  localparam mode_t EXPS [8] = '{MODE_IDLE, MODE_SLEEP, MODE_SLEEP, MODE_IDLE,
                                 MODE_IDLE, MODE_ACTIVE, MODE_ACTIVE, MODE_AIRPLANE};
  logic        clk         = 1'b0;
  logic        reset;
  logic        main_supply;
  logic        fault;
  activity_t   activity;
  logic        restart_cmd;
  logic        init_done;
  logic        ign_n;
  logic        rst_n;
  mode_t       mode;
  logic        core_reset;
  logic        rtc_only;
  logic        radio_on;
  logic        radio_cmd_reject;
  logic        volatile_clear;
  port_lines_t port_lines;
  int          miscompares = 0;
  int          tests_run   = 0;

  always #25 clk = ~clk;

  module_power_mode_sequencer #(.TICK_CYC(TICK)) i_module_power_mode_sequencer (
    .clk(clk), .reset(reset), .power_on_trigger_n(ign_n), .emergency_reset_n(rst_n),
    .main_supply(main_supply), .fault(fault), .activity(activity),
    .restart_cmd(restart_cmd), .init_done(init_done), .mode(mode),
    .core_reset(core_reset), .rtc_only(rtc_only), .radio_on(radio_on),
    .radio_cmd_reject(radio_cmd_reject), .volatile_clear(volatile_clear),
    .port_lines(port_lines));

  host_controller #(.TICK_CYC(TICK)) i_host_controller (
    .clk(clk), .ign_n(ign_n), .rst_n(rst_n));

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : cmp

  // bounded poll, so a one-cycle mode is still caught at a falling edge
  task automatic wait_mode(input mode_t m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      @(negedge clk);
      n++;
    end
    cmp(8'(mode), 8'(m));
  endtask : wait_mode

  task automatic done(input string s);
    $display("test %s done, mismatches %0d", s, miscompares);
  endtask : done

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic t_reset;
    cmp(8'(mode), 8'(MODE_DOWN));
    cmp(8'({core_reset, rtc_only, radio_on, radio_cmd_reject, volatile_clear}), 8'h1B);
    cmp(8'(port_lines), 8'h07);
    done("reset");
  endtask : t_reset

  task automatic t_start;
    i_host_controller.hold_ign(100);
    repeat (8) @(negedge clk);
    cmp(8'(mode), 8'(MODE_DOWN));
    i_host_controller.hold_ign(310);
    cmp(8'(mode), 8'(MODE_BOOT));
    cmp(8'({core_reset, rtc_only}), 8'h00);
    cmp(8'(port_lines), 8'h07);
    init_done = 1'b1;
    wait_mode(MODE_IDLE, 60 * TICK);
    cmp(8'(port_lines), 8'h00);
    done("start");
  endtask : t_start

  task automatic t_modes;
    for (int i = 0; i < 8; i++) begin
      activity = activity_t'(ACTS[i]);
      repeat (6) @(negedge clk);
      cmp(8'(mode), 8'(EXPS[i]));
      cmp(8'(radio_on), 8'(EXPS[i] != MODE_AIRPLANE));
      cmp(8'(radio_cmd_reject), 8'(EXPS[i] == MODE_AIRPLANE));
    end
    activity = activity_t'(7'h08);
    wait_mode(MODE_IDLE, 8);
    done("modes");
  endtask : t_modes

  // firmware not ready yet: boot must hold past its minimum time
  task automatic t_cmd;
    init_done   = 1'b0;
    restart_cmd = 1'b1;
    @(negedge clk);
    restart_cmd = 1'b0;
    cmp(8'(mode), 8'(MODE_RESET));
    cmp(8'(volatile_clear), 8'h01);
    @(negedge clk);
    cmp(8'(mode), 8'(MODE_BOOT));
    repeat (60 * TICK) @(negedge clk);
    cmp(8'(mode), 8'(MODE_BOOT));
    cmp(8'(port_lines), 8'h07);
    init_done = 1'b1;
    wait_mode(MODE_IDLE, 8);
    done("restart command");
  endtask : t_cmd

  task automatic t_emerg;
    fork
      i_host_controller.hold_rst(250);
      begin
        wait_mode(MODE_RESET, 250 * TICK);
        cmp(8'({core_reset, volatile_clear, port_lines}), 8'h1F);
        @(negedge clk);
        wait_mode(MODE_RESET, 8);
      end
    join
    wait_mode(MODE_IDLE, 100 * TICK);
    done("emergency reset");
  endtask : t_emerg

  task automatic t_fault;
    fault = 1'b1;
    repeat (2) @(negedge clk);
    cmp(8'(mode), 8'(MODE_DOWN));
    cmp(8'(rtc_only), 8'h01);
    fault = 1'b0;
    done("fault");
  endtask : t_fault

  // ignition stays tied low, so every return to power down restarts
  task automatic t_tied;
    i_host_controller.set_ign(1'b0);
    wait_mode(MODE_BOOT, 320 * TICK);
    wait_mode(MODE_IDLE, 100 * TICK);
    main_supply = 1'b0;
    repeat (2) @(negedge clk);
    cmp(8'(mode), 8'(MODE_DOWN));
    main_supply = 1'b1;
    wait_mode(MODE_BOOT, 20);
    i_host_controller.set_ign(1'b1);
    wait_mode(MODE_IDLE, 100 * TICK);
    done("tied ignition");
  endtask : t_tied

  task automatic t_emerg_long;
    fork
      i_host_controller.hold_rst(8010);
      begin
        wait_mode(MODE_RESET, 250 * TICK);
        wait_mode(MODE_DOWN, 7900 * TICK);
        cmp(8'(rtc_only), 8'h01);
      end
    join
    repeat (8) @(negedge clk);
    cmp(8'(mode), 8'(MODE_DOWN));
    done("emergency switch off");
  endtask : t_emerg_long

  initial begin
    reset       = 1'b1;
    main_supply = 1'b1;
    fault       = 1'b0;
    activity    = activity_t'(7'h08);
    restart_cmd = 1'b0;
    init_done   = 1'b0;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    t_reset();
    t_start();
    t_modes();
    t_cmd();
    t_emerg();
    t_fault();
    t_tied();
    t_emerg_long();
    finish_test();
  end

  // the whole sequence needs about 40000 cycles
  initial begin
    repeat (60000) @(negedge clk);
    miscompares++;
    finish_test();
  end
endmodule : tb_module_power_mode_sequencer
